// ---- hdl/odd_gray_duration_table_upper.sv ----
/*
 * Upper odd-column gray duration table (levels 11 to 15) with its
 * drive timer for the odd column outputs.
 * Assumes the host splits each command word into code and value on the
 * register port, and that the column logic asks for one drive at a time.
 */
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module odd_gray_duration_table_upper #(
	parameter int ENTRY_W = 8
) (
	input wire logic CLK_IN,
	input wire logic RESETN_IN,
	input wire logic CE_IN,
	input wire logic [odd_table_pkg::CODE_W-1:0] ADDR_IN,
	input wire logic [odd_table_pkg::DATA_W-1:0] WDATA_IN,
	input wire logic WR_STROBE_IN,
	input wire logic RD_STROBE_IN,
	output logic [odd_table_pkg::DATA_W-1:0] RDATA_OUT,
	input wire logic [1:0] DISPLAY_MODE_IN,
	input wire logic DRIVE_START_IN,
	input wire logic [3:0] DRIVE_LEVEL_IN,
	output logic DRIVE_ACTIVE_OUT,
	output logic DRIVE_DONE_OUT,
	output logic [ENTRY_W-1:0] LEVEL15_PERIOD_COUNT_OUT,
	output logic [ENTRY_W-1:0] LEVEL14_PERIOD_COUNT_OUT,
	output logic [ENTRY_W-1:0] LEVEL13_PERIOD_COUNT_OUT,
	output logic [ENTRY_W-1:0] LEVEL12_PERIOD_COUNT_OUT,
	output logic [ENTRY_W-1:0] LEVEL11_PERIOD_COUNT_OUT
);

	import odd_table_pkg::*;

	logic [ENTRY_W-1:0] entry_reg [0:NUM_ENTRIES-1];
	logic [ENTRY_W-1:0] entry_next [0:NUM_ENTRIES-1];
	logic [NUM_ENTRIES-1:0] entry_hit;
	logic load_any;
	logic mode_ok;
	logic status_read;
	logic level_in_range;
	logic [3:0] level_offset;
	logic start_ok;
	logic start_refused;
	logic [ENTRY_W-1:0] sel_value;
	logic timer_busy;
	logic timer_done;
	logic misuse_reg;
	logic misuse_next;
	logic refused_reg;
	logic refused_next;
	logic [DATA_W-1:0] rdata_reg;
	logic [DATA_W-1:0] rdata_next;
	logic [DATA_W-1:0] status_word;

	// Drive requests are only taken in 16-level gray operation; loads in other modes still take and set misuse
	assign mode_ok = (DISPLAY_MODE_IN == MODE_GRAY16);

	// One entry per generate step: decode its code, load it, keep it
	generate
		for (genvar i = 0; i < NUM_ENTRIES; i++) begin : g_entry
			assign entry_hit[i] = WR_STROBE_IN && (ADDR_IN == ENTRY_CODE[i]);

			always_comb begin
				entry_next[i] = entry_reg[i];
				if (entry_hit[i]) begin
					entry_next[i] = WDATA_IN[ENTRY_W-1:0];
				end
			end

			always_ff @(posedge CLK_IN) begin
				if (!RESETN_IN) begin
					entry_reg[i] <= ENTRY_RST[i][ENTRY_W-1:0];
				end else if (CE_IN) begin
					entry_reg[i] <= entry_next[i];
				end
			end
		end
	endgenerate

	// Any load command seen this cycle
	assign load_any = |entry_hit;

	assign LEVEL13_PERIOD_COUNT_OUT = entry_reg[2];
	assign LEVEL12_PERIOD_COUNT_OUT = entry_reg[3];
	assign LEVEL11_PERIOD_COUNT_OUT = entry_reg[4];
	// Levels 15 and 14 entries out
	assign LEVEL15_PERIOD_COUNT_OUT = entry_reg[0];
	assign LEVEL14_PERIOD_COUNT_OUT = entry_reg[1];

	// Drive request decode: only levels 11 to 15 belong to this table
	assign level_in_range = (DRIVE_LEVEL_IN >= BOTTOM_LEVEL) && (DRIVE_LEVEL_IN <= TOP_LEVEL);
	assign level_offset = TOP_LEVEL - DRIVE_LEVEL_IN;

	always_comb begin
		sel_value = '0;
		for (int k = 0; k < NUM_ENTRIES; k++) begin
			if (level_offset == 4'(k)) begin
				sel_value = entry_reg[k];
			end
		end
	end

	// A request is taken only when idle, in range and in 16-level mode
	assign start_ok = DRIVE_START_IN && !timer_busy && level_in_range && mode_ok;
	assign start_refused = DRIVE_START_IN && !start_ok;

	period_timer #(
		.COUNT_W(ENTRY_W)
	) u_drive_timer (
		.clk_in(CLK_IN),
		.resetn_in(RESETN_IN),
		.ce_in(CE_IN),
		.start_in(start_ok),
		.value_in(sel_value),
		.busy_out(timer_busy),
		.done_out(timer_done)
	);

	// Drive window seen by the column output stage
	assign DRIVE_ACTIVE_OUT = timer_busy;
	assign DRIVE_DONE_OUT = timer_done;

	// A status read clears the sticky bits
	assign status_read = RD_STROBE_IN && (ADDR_IN == STATUS_ADDR);

	always_comb begin
		misuse_next = misuse_reg;
		refused_next = refused_reg;
		if (status_read) begin
			misuse_next = 1'b0;
			refused_next = 1'b0;
		end
		// A new event in the clearing cycle is kept
		if (load_any && !mode_ok) begin
			misuse_next = 1'b1;
		end
		if (start_refused) begin
			refused_next = 1'b1;
		end
	end

	// Sticky status flags
	always_ff @(posedge CLK_IN) begin
		if (!RESETN_IN) begin
			misuse_reg <= STATUS_RST[STATUS_MISUSE_BIT];
			refused_reg <= STATUS_RST[STATUS_REFUSED_BIT];
		end else if (CE_IN) begin
			misuse_reg <= misuse_next;
			refused_reg <= refused_next;
		end
	end

	// Status word as read by software
	always_comb begin
		status_word = STATUS_RST;
		status_word[STATUS_ACTIVE_BIT] = timer_busy;
		status_word[STATUS_MISUSE_BIT] = misuse_reg;
		status_word[STATUS_REFUSED_BIT] = refused_reg;
	end

	always_comb begin
		rdata_next = READ_IDLE;
		if (status_read) begin
			rdata_next = status_word;
		end
	end

	// Read data stand for the one cycle after the read strobe
	always_ff @(posedge CLK_IN) begin
		if (!RESETN_IN) begin
			rdata_reg <= READ_IDLE;
		end else if (CE_IN) begin
			rdata_reg <= rdata_next;
		end
	end

	assign RDATA_OUT = rdata_reg;

endmodule

`default_nettype wire

// ---- common/odd_table_pkg.sv ----
/*
 * Constants for the upper odd-column gray duration table: command codes,
 * entry reset values, status layout and display mode codes.
 * Assumes a 16-bit command word split into an 8-bit code and an 8-bit value.
 */
`default_nettype none

package odd_table_pkg;

	// Command word layout
	localparam int CMD_WORD_W = 16;
	localparam int CMD_CODE_MSB = 15;
	localparam int CMD_CODE_LSB = 8;
	localparam int CMD_DATA_MSB = 7;
	localparam int CMD_DATA_LSB = 0;
	localparam int CODE_W = CMD_CODE_MSB - CMD_CODE_LSB + 1;
	localparam int DATA_W = CMD_DATA_MSB - CMD_DATA_LSB + 1;

	// Number of table entries held here, highest gray level first
	localparam int NUM_ENTRIES = 5;
	localparam logic [3:0] TOP_LEVEL = 4'hF;
	localparam logic [3:0] BOTTOM_LEVEL = 4'hB;

	// Load command codes
	localparam logic [7:0] LOAD_ODD_LEVEL15_CMD = 8'h1F;
	localparam logic [7:0] LOAD_ODD_LEVEL14_CMD = 8'h20;
	localparam logic [7:0] LOAD_ODD_LEVEL13_CMD = 8'h21;
	localparam logic [7:0] LOAD_ODD_LEVEL12_CMD = 8'h22;
	localparam logic [7:0] LOAD_ODD_LEVEL11_CMD = 8'h23;

	// Entry reset values
	localparam logic [7:0] ODD_LEVEL15_DURATION_RST = 8'hFF;
	localparam logic [7:0] ODD_LEVEL14_DURATION_RST = 8'hAF;
	localparam logic [7:0] ODD_LEVEL13_DURATION_RST = 8'h79;
	localparam logic [7:0] ODD_LEVEL12_DURATION_RST = 8'h53;
	localparam logic [7:0] ODD_LEVEL11_DURATION_RST = 8'h39;

	// Tables indexed by entry, entry 0 is level 15
	localparam logic [7:0] ENTRY_CODE [0:NUM_ENTRIES-1] = '{LOAD_ODD_LEVEL15_CMD,
		LOAD_ODD_LEVEL14_CMD, LOAD_ODD_LEVEL13_CMD, LOAD_ODD_LEVEL12_CMD, LOAD_ODD_LEVEL11_CMD};
	localparam logic [7:0] ENTRY_RST [0:NUM_ENTRIES-1] = '{ODD_LEVEL15_DURATION_RST,
		ODD_LEVEL14_DURATION_RST, ODD_LEVEL13_DURATION_RST, ODD_LEVEL12_DURATION_RST,
		ODD_LEVEL11_DURATION_RST};

	// Status register, readable, misuse and refused bits clear on read
	localparam logic [7:0] STATUS_ADDR = 8'h80;
	localparam int STATUS_ACTIVE_BIT = 0;
	localparam int STATUS_MISUSE_BIT = 1;
	localparam int STATUS_REFUSED_BIT = 2;
	localparam logic [7:0] STATUS_RST = 8'h00;
	localparam logic [7:0] READ_IDLE = 8'h00;

	// Display mode codes on the mode input
	localparam logic [1:0] MODE_GRAY16 = 2'h0;
	localparam logic [1:0] MODE_GRAY4 = 2'h1;
	localparam logic [1:0] MODE_GRAY64 = 2'h2;
	localparam logic [1:0] MODE_MONO = 2'h3;

endpackage

`default_nettype wire

// ---- hdl/period_timer.sv ----
/*
 * Period timer: once started with a value N it holds busy for N+1 clock
 * periods, then pulses done in its last busy cycle.
 * Assumes the start pulse is only given while the timer is idle.
 */
`timescale 1ns/1ps
`default_nettype none

module period_timer #(
	parameter int COUNT_W = 8
) (
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic ce_in,
	input wire logic start_in,
	input wire logic [COUNT_W-1:0] value_in,
	output logic busy_out,
	output logic done_out
);

	typedef enum logic {IDLE, RUN} timer_state_t;

	timer_state_t state_reg;
	timer_state_t state_next;
	logic [COUNT_W-1:0] count_reg;
	logic [COUNT_W-1:0] count_next;

	// Next state: load on start, count down, stop after count zero
	always_comb begin
		state_next = state_reg;
		count_next = count_reg;
		case (state_reg)
			IDLE: begin
				if (start_in) begin
					state_next = RUN;
					count_next = value_in;
				end
			end
			RUN: begin
				if (count_reg == '0) begin
					state_next = IDLE;
				end else begin
					count_next = count_reg - 1'b1;
				end
			end
			default: begin
				state_next = IDLE;
				count_next = '0;
			end
		endcase
	end

	// State registers, frozen while the clock enable is low
	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			state_reg <= IDLE;
			count_reg <= '0;
		end else if (ce_in) begin
			state_reg <= state_next;
			count_reg <= count_next;
		end
	end

	// Busy spans N+1 cycles, done marks the last of them
	assign busy_out = (state_reg == RUN);
	assign done_out = (state_reg == RUN) && (count_reg == '0);

endmodule

`default_nettype wire

// ---- sim/odd_table_monitor.sv ----
/* Checker for the upper odd duration table: loads, reset values, readback, drive timing.
 * Bound to the table's top module; sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module odd_table_monitor #(parameter int ENTRY_W = 8) (
	input wire logic CLK_IN, RESETN_IN, CE_IN, WR_STROBE_IN, RD_STROBE_IN, DRIVE_START_IN,
	input wire logic DRIVE_ACTIVE_OUT, DRIVE_DONE_OUT,
	input wire logic [7:0] ADDR_IN, WDATA_IN, RDATA_OUT,
	input wire logic [1:0] DISPLAY_MODE_IN,
	input wire logic [3:0] DRIVE_LEVEL_IN,
	input wire logic [ENTRY_W-1:0] LEVEL15_PERIOD_COUNT_OUT, LEVEL14_PERIOD_COUNT_OUT, LEVEL11_PERIOD_COUNT_OUT
);
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (!RESETN_IN);
	// Taken load and accepted drive request
	wire logic wr = CE_IN && WR_STROBE_IN;
	wire logic take = CE_IN && DRIVE_START_IN && !DRIVE_ACTIVE_OUT && DISPLAY_MODE_IN == 2'h0;
	// Entry loads, reset values and readback
	AST_LOAD15: assert property (wr && ADDR_IN == 8'h1F |=> LEVEL15_PERIOD_COUNT_OUT == $past(WDATA_IN))
		else $error("level 15 load lost");
	AST_LOAD14: assert property (wr && ADDR_IN == 8'h20 |=> LEVEL14_PERIOD_COUNT_OUT == $past(WDATA_IN))
		else $error("level 14 load lost");
	AST_LOAD11: assert property (wr && ADDR_IN == 8'h23 |=> LEVEL11_PERIOD_COUNT_OUT == $past(WDATA_IN))
		else $error("level 11 load lost");
	AST_RESET: assert property (disable iff (1'b0) !RESETN_IN |=> LEVEL15_PERIOD_COUNT_OUT == 8'hFF
		&& LEVEL14_PERIOD_COUNT_OUT == 8'hAF && LEVEL11_PERIOD_COUNT_OUT == 8'h39) else $error("bad reset value");
	AST_NO_READBACK: assert property (CE_IN && RD_STROBE_IN && ADDR_IN != 8'h80 |=> RDATA_OUT == 8'h00)
		else $error("entry read back");
	// Drive timing
	AST_START: assert property (take && DRIVE_LEVEL_IN >= 4'hB |=> DRIVE_ACTIVE_OUT)
		else $error("drive not started");
	AST_SHORTEST: assert property (take && DRIVE_LEVEL_IN == 4'hF && LEVEL15_PERIOD_COUNT_OUT == 8'h00
		|=> DRIVE_DONE_OUT ##1 !DRIVE_ACTIVE_OUT) else $error("zero entry not one period");
	AST_DONE_LAST: assert property (DRIVE_DONE_OUT && CE_IN |=> !DRIVE_ACTIVE_OUT)
		else $error("drive ran past done");
	COV_LOAD: cover property (wr);
	COV_READ: cover property (CE_IN && RD_STROBE_IN);
	COV_DONE: cover property (DRIVE_DONE_OUT);
endmodule
bind odd_gray_duration_table_upper odd_table_monitor #(.ENTRY_W(ENTRY_W)) i_mon (.CLK_IN, .RESETN_IN, .CE_IN,
	.WR_STROBE_IN, .RD_STROBE_IN, .DRIVE_START_IN, .DRIVE_ACTIVE_OUT, .DRIVE_DONE_OUT, .ADDR_IN, .WDATA_IN,
	.RDATA_OUT, .DISPLAY_MODE_IN, .DRIVE_LEVEL_IN, .LEVEL15_PERIOD_COUNT_OUT, .LEVEL14_PERIOD_COUNT_OUT,
	.LEVEL11_PERIOD_COUNT_OUT);
`default_nettype wire

// ---- sim/host_model.sv ----
/* Host model: issues command words and reads on the table's register port.
 * Shares the table's clock; changes signals just after rising edges. */
`timescale 1ns/1ps
`default_nettype none
module host_model (
	input wire logic clk_in,
	input wire logic [7:0] rdata_in,
	output var logic [7:0] addr_out,
	output var logic [7:0] wdata_out,
	output var logic wr_out,
	output var logic rd_out,
	output var logic [1:0] mode_out
);
	import odd_table_pkg::*;
	initial begin
		addr_out = 8'h00;
		wdata_out = 8'h00;
		wr_out = 1'b0;
		rd_out = 1'b0;
		mode_out = MODE_GRAY16;
	end
	// Mode change, only a scenario asks for another mode
	task automatic set_mode(input logic [1:0] m);
		@(posedge clk_in);
		mode_out <= m;
	endtask
	task automatic wr(input logic [15:0] word);
		@(posedge clk_in);
		addr_out <= word[15:8];
		wdata_out <= word[7:0];
		wr_out <= 1'b1;
		@(posedge clk_in);
		wr_out <= 1'b0;
		wdata_out <= ~word[7:0];
	endtask
	// Read data taken in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_in);
		addr_out <= a;
		rd_out <= 1'b1;
		@(posedge clk_in);
		rd_out <= 1'b0;
		@(posedge clk_in);
		d = rdata_in;
	endtask
endmodule
`default_nettype wire

// ---- sim/odd_gray_duration_table_upper_tb.sv ----
/* Testbench for the upper odd duration table: loads, readback, drive lengths, refusals.
 * Drives the register port through the host model at 10 MHz. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin errors++; $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end
module odd_gray_duration_table_upper_tb;
	import odd_table_pkg::*;
	logic clk_in = 1'b0, resetn_in, ce_in, start_in, wr, rd, active, done;
	logic [3:0] level_in;
	logic [7:0] addr, wdata, rdata, d;
	logic [1:0] mode;
	logic [7:0] ent [5];
	int errors = 0, checks_done = 0, n;
	localparam logic [7:0] RST_EXP [5] = '{8'hFF, 8'hAF, 8'h79, 8'h53, 8'h39};
	localparam logic [7:0] CODES [5] = '{8'h1F, 8'h20, 8'h21, 8'h22, 8'h23};
	always #50 clk_in = ~clk_in;
	odd_gray_duration_table_upper i_dut (.CLK_IN(clk_in), .RESETN_IN(resetn_in), .CE_IN(ce_in), .ADDR_IN(addr),
		.WDATA_IN(wdata), .WR_STROBE_IN(wr), .RD_STROBE_IN(rd), .RDATA_OUT(rdata), .DISPLAY_MODE_IN(mode),
		.DRIVE_START_IN(start_in), .DRIVE_LEVEL_IN(level_in), .DRIVE_ACTIVE_OUT(active), .DRIVE_DONE_OUT(done),
		.LEVEL15_PERIOD_COUNT_OUT(ent[0]), .LEVEL14_PERIOD_COUNT_OUT(ent[1]), .LEVEL13_PERIOD_COUNT_OUT(ent[2]),
		.LEVEL12_PERIOD_COUNT_OUT(ent[3]), .LEVEL11_PERIOD_COUNT_OUT(ent[4]));
	host_model i_host (.clk_in(clk_in), .rdata_in(rdata), .addr_out(addr), .wdata_out(wdata), .wr_out(wr),
		.rd_out(rd), .mode_out(mode));
	// Verdict and end of run
	task automatic close_out();
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// All entries at their reset values
	task automatic chk_rst();
		for (int i = 0; i < 5; i++) begin
			`CHK(ent[i], RST_EXP[i])
		end
	endtask
	// One drive request, counts its active cycles into n
	task automatic drive(input logic [3:0] l);
		@(posedge clk_in);
		start_in <= 1'b1;
		level_in <= l;
		@(posedge clk_in);
		start_in <= 1'b0;
		n = 0;
		@(posedge clk_in);
		while (active === 1'b1 && n < 300) begin
			n++;
			@(posedge clk_in);
		end
	endtask
	// Main sequence
	initial begin
		resetn_in <= 1'b0;
		ce_in <= 1'b1;
		start_in <= 1'b0;
		level_in <= 4'hF;
		repeat (16) @(posedge clk_in);
		resetn_in <= 1'b1;
		chk_rst();
		for (int i = 0; i < 5; i++) begin
			i_host.wr({CODES[i], 8'(8'h10 + i)});
		end
		i_host.wr(16'h2455);
		@(posedge clk_in);
		ce_in <= 1'b0;
		i_host.wr(16'h1F77);
		ce_in <= 1'b1;
		for (int i = 0; i < 5; i++) begin
			`CHK(ent[i], 8'(8'h10 + i))
			i_host.rd(CODES[i], d);
			`CHK(d, 8'h00)
		end
		i_host.wr(16'h1F00);
		drive(4'hF);
		`CHK(n, 1)
		i_host.wr(16'h23FF);
		drive(4'hB);
		`CHK(n, 256)
		i_host.wr(16'h207F);
		drive(4'hE);
		`CHK(n, 128)
		drive(4'hA);
		`CHK(n, 0)
		i_host.set_mode(MODE_GRAY4);
		drive(4'hF);
		`CHK(n, 0)
		i_host.rd(8'h80, d);
		`CHK(d, 8'h04)
		i_host.set_mode(MODE_MONO);
		i_host.wr(16'h2166);
		i_host.set_mode(MODE_GRAY16);
		`CHK(ent[2], 8'h66)
		i_host.rd(8'h80, d);
		`CHK(d, 8'h02)
		@(posedge clk_in);
		resetn_in <= 1'b0;
		@(posedge clk_in);
		resetn_in <= 1'b1;
		@(posedge clk_in);
		chk_rst();
		close_out();
	end
	// Watchdog over the expected run length
	initial begin
		#200000;
		errors++;
		close_out();
	end
endmodule
`default_nettype wire
